//--- rtl/dsau_dma_ram.sv
// data space access unit: dual ported buffer ram
// assumes cpu side read is used combinationally and registered by the caller
`timescale 1ns/1ps
`default_nettype none

module dsau_dma_ram #(
  parameter int WORDS = 1024,
  parameter int AW = 10
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic [1:0] cpu_lanes,
  input wire logic [AW-1:0] cpu_idx,
  input wire logic [15:0] cpu_wdata,
  output logic [15:0] cpu_rdata,
  input wire logic dma_req,
  input wire logic dma_we,
  input wire logic [1:0] dma_be,
  input wire logic [AW-1:0] dma_idx,
  input wire logic [15:0] dma_wdata,
  output logic [15:0] dma_rdata,
  output logic dma_rvalid,
  output logic dma_collision
);
  logic [15:0] mem [WORDS];

  // ==========================================
  // lane arbitration
  wire same = cpu_idx == dma_idx;
  wire [1:0] dma_lanes = (dma_req && dma_we) ? dma_be : 2'b00;
  wire [1:0] dma_keep = dma_lanes & ~(same ? cpu_lanes : 2'b00);
  wire clash = same && |(cpu_lanes & dma_lanes);

  assign cpu_rdata = mem[cpu_idx];

  // cpu lane wins outright, no stall path exists
  always_ff @(posedge clock) begin
    for (int l = 0; l < 2; l++) begin
      if (dma_keep[l]) begin
        mem[dma_idx][l*8 +: 8] <= dma_wdata[l*8 +: 8];
      end
      if (cpu_lanes[l]) begin
        mem[cpu_idx][l*8 +: 8] <= cpu_wdata[l*8 +: 8];
      end
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      dma_rdata <= 16'h0000;
      dma_rvalid <= 1'b0;
      dma_collision <= 1'b0;
    end else begin
      dma_rvalid <= dma_req && !dma_we;
      if (dma_req && !dma_we) begin
        dma_rdata <= mem[dma_idx];
      end
      dma_collision <= clash;
    end
  end

  // ==========================================
  // checks
  property p_cpu_wins_lo;
    @(posedge clock) disable iff (reset)
    (clash && cpu_lanes[0] && dma_lanes[0]) |=>
      mem[$past(cpu_idx)][7:0] == $past(cpu_wdata[7:0]);
  endproperty
  a_cpu_wins_lo: assert property (p_cpu_wins_lo) else $error("dma write beat cpu");
endmodule : dsau_dma_ram
`default_nettype wire

//--- rtl/dsau_params.svh
// data space access unit: address map and reset constants
// assumes a 16-bit byte-addressed data space, one core clock
`ifndef DSAU_PARAMS_SVH
`define DSAU_PARAMS_SVH

// ==========================================
// working registers, mapped as words
`define DSAU_WREG_BASE 16'h0000
`define DSAU_OFF_WORKING_REG_0 16'h0000
`define DSAU_OFF_WORKING_REG_2 16'h0004
`define DSAU_OFF_WORKING_REG_5 16'h000a
`define DSAU_OFF_WORKING_REG_6 16'h000c
`define DSAU_OFF_WORKING_REG_8 16'h0010
`define DSAU_WREG_END 16'h0020
`define DSAU_WREG_RESET 16'h0000

// ==========================================
// regions
`define DSAU_SFR_LAST 16'h07ff
`define DSAU_NEAR_LAST 16'h1fff
`define DSAU_NEAR_BITS 13
`define DSAU_RAM_BASE 16'h0800
`define DSAU_DMA_BASE 16'h2000
`define DSAU_DMA_BYTES 16'h0800

// ==========================================
// pointer steps
`define DSAU_INC_BYTE 16'h0001
`define DSAU_INC_WORD 16'h0002

`endif

//--- rtl/dsau_pkg.sv
// data space access unit: shared types
// assumes nothing beyond a SystemVerilog compiler
package dsau_pkg;
  typedef enum logic [1:0] {
    MODE_DIRECT13 = 2'h0,
    MODE_DIRECT16 = 2'h1,
    MODE_INDIRECT = 2'h2
  } dsau_mode_t;

  typedef enum logic [1:0] {
    OP_LOAD_WORD = 2'h0,
    OP_LOAD_BYTE = 2'h1,
    OP_SIGN_EXT = 2'h2,
    OP_ZERO_EXT = 2'h3
  } dsau_reg_op_t;

  typedef enum logic [2:0] {
    REG_WREG = 3'h0,
    REG_SFR = 3'h1,
    REG_RAM = 3'h2,
    REG_DMA = 3'h3,
    REG_NONE = 3'h4
  } dsau_region_t;

  typedef enum logic [1:0] {
    TRAP_IDLE = 2'b01,
    TRAP_PENDING = 2'b10
  } dsau_trap_state_t;
endpackage : dsau_pkg

//--- rtl/dsau_top.sv
// data space access unit: address generation, decode, lanes, trap, ram
// assumes cpu and dma requests arrive on the core clock, one per cycle each
//
// Functional notes
// - post-increment adds one for byte operations, two for word operations
// - byte read takes whole word, picks by address bit zero, low lane out
// - one word decode, per-lane write strobes; byte write touches one lane
// - word access at odd address raises the address-error trap
// - misaligned read lets the instruction finish before the trap
// - misaligned write is suppressed, instruction runs, then trap
// - byte load into a working register keeps its high byte
// - sign-extend widens low byte to sixteen bits; zero-extend clears high byte
// - 0x0000 to 0x07ff is register space; unimplemented locations read zero
// - near space 0x0000 to 0x1fff reachable through a 13-bit direct field
// - whole space reachable by 16-bit direct address or register pointer
// - 2-Kbyte dual ported buffer at top, shared without taking cpu cycles
// - simultaneous same-word writes: cpu wins, cpu never stalls
// - addresses outside implemented memory read all zero
// - low byte at even address, high byte at odd address
`timescale 1ns/1ps
`default_nettype none
`include "dsau_params.svh"

module dsau_top #(
  parameter int NUM_WREG = 16,
  parameter int RAM_WORDS = 3072,
  parameter int RAM_AW = 12,
  parameter int DMA_WORDS = 1024,
  parameter int DMA_AW = 10
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic cpu_req,
  input wire logic cpu_we,
  input wire logic cpu_byte,
  input wire dsau_pkg::dsau_mode_t cpu_mode,
  input wire logic [15:0] cpu_direct_addr,
  input wire logic [3:0] cpu_ptr_sel,
  input wire logic cpu_post_inc,
  input wire logic [15:0] cpu_wdata,
  input wire logic cpu_insn_done,
  input wire logic reg_op_valid,
  input wire dsau_pkg::dsau_reg_op_t reg_op,
  input wire logic [3:0] reg_op_dst,
  input wire logic [15:0] reg_op_data,
  input wire logic dma_req,
  input wire logic dma_we,
  input wire logic [1:0] dma_be,
  input wire logic [DMA_AW-1:0] dma_word_addr,
  input wire logic [15:0] dma_wdata,
  output logic [15:0] cpu_rdata,
  output logic cpu_rvalid,
  output logic [15:0] cpu_ea,
  output logic addr_error_trap,
  output logic [15:0] dma_rdata,
  output logic dma_rvalid,
  output logic dma_collision
);
  // ==========================================
  // functions
  function automatic dsau_pkg::dsau_region_t region_of(input logic [15:0] a);
    if (a < `DSAU_WREG_END) begin
      return dsau_pkg::REG_WREG;
    end else if (a <= `DSAU_SFR_LAST) begin
      return dsau_pkg::REG_SFR;
    end else if (a < `DSAU_DMA_BASE) begin
      return dsau_pkg::REG_RAM;
    end else if (a < 16'(`DSAU_DMA_BASE + `DSAU_DMA_BYTES)) begin
      return dsau_pkg::REG_DMA;
    end else begin
      return dsau_pkg::REG_NONE;
    end
  endfunction : region_of

  // even address = low lane, odd = high lane
  function automatic logic [1:0] lanes_of(input logic byte_op, input logic a0);
    if (!byte_op) begin
      return 2'b11;
    end
    return a0 ? 2'b10 : 2'b01;
  endfunction : lanes_of

  function automatic logic [7:0] pick_byte(input logic [15:0] w, input logic a0);
    return a0 ? w[15:8] : w[7:0];
  endfunction : pick_byte

  // ==========================================
  // effective address
  logic [NUM_WREG-1:0][15:0] regs;
  wire [15:0] ptr_value = regs[cpu_ptr_sel];
  wire [15:0] near_ea = 16'(cpu_direct_addr[`DSAU_NEAR_BITS-1:0]);
  wire [15:0] ea = (cpu_mode == dsau_pkg::MODE_INDIRECT) ? ptr_value :
                   (cpu_mode == dsau_pkg::MODE_DIRECT16) ? cpu_direct_addr : near_ea;
  wire dsau_pkg::dsau_region_t region = region_of(ea);
  wire misaligned = cpu_req && !cpu_byte && ea[0];
  wire do_write = cpu_req && cpu_we && !misaligned;
  wire [1:0] wr_lanes = do_write ? lanes_of(cpu_byte, ea[0]) : 2'b00;
  wire [15:0] wr_data = cpu_byte ? {cpu_wdata[7:0], cpu_wdata[7:0]} : cpu_wdata;
  wire [15:0] inc_step = cpu_byte ? `DSAU_INC_BYTE : `DSAU_INC_WORD;
  wire inc_en = cpu_req && cpu_mode == dsau_pkg::MODE_INDIRECT && cpu_post_inc;

  // ==========================================
  // working register write port
  wire [15:0] op_src = regs[reg_op_dst];
  logic [1:0] op_lanes;
  logic [15:0] op_data;
  always_comb begin
    op_lanes = 2'b11;
    op_data = reg_op_data;
    case (reg_op)
      dsau_pkg::OP_LOAD_WORD: begin
        op_data = reg_op_data;
      end
      dsau_pkg::OP_LOAD_BYTE: begin
        op_lanes = 2'b01;
        op_data = {8'h00, reg_op_data[7:0]};
      end
      dsau_pkg::OP_SIGN_EXT: begin
        op_data = {{8{op_src[7]}}, op_src[7:0]};
      end
      dsau_pkg::OP_ZERO_EXT: begin
        op_data = {8'h00, op_src[7:0]};
      end
      default: begin
        op_lanes = 2'b00;
      end
    endcase
  end

  // register ops take the port; a same-cycle mapped write is dropped
  wire wreg_hit = region == dsau_pkg::REG_WREG;
  wire [1:0] a_lanes = reg_op_valid ? op_lanes : (wreg_hit ? wr_lanes : 2'b00);
  wire [3:0] a_idx = reg_op_valid ? reg_op_dst : ea[4:1];
  wire [15:0] a_data = reg_op_valid ? op_data : wr_data;

  dsau_wreg_file #(
    .NUM_WREG(NUM_WREG)
  ) u_wreg (
    .clock(clock),
    .reset(reset),
    .a_lanes(a_lanes),
    .a_idx(a_idx),
    .a_data(a_data),
    .inc_en(inc_en),
    .inc_idx(cpu_ptr_sel),
    .inc_step(inc_step),
    .regs(regs)
  );

  // ==========================================
  // general ram
  logic [15:0] ram [RAM_WORDS];
  wire [15:0] ram_off = ea - `DSAU_RAM_BASE;
  wire [RAM_AW-1:0] ram_idx = ram_off[RAM_AW:1];
  wire [1:0] ram_lanes = (region == dsau_pkg::REG_RAM) ? wr_lanes : 2'b00;

  always_ff @(posedge clock) begin
    for (int l = 0; l < 2; l++) begin
      if (ram_lanes[l]) begin
        ram[ram_idx][l*8 +: 8] <= wr_data[l*8 +: 8];
      end
    end
  end

  // ==========================================
  // buffer ram, dma side never waits on the cpu
  wire [15:0] dma_off = ea - `DSAU_DMA_BASE;
  wire [DMA_AW-1:0] dma_cpu_idx = dma_off[DMA_AW:1];
  wire [1:0] dma_cpu_lanes = (region == dsau_pkg::REG_DMA) ? wr_lanes : 2'b00;
  wire [15:0] dma_cpu_rd;

  dsau_dma_ram #(
    .WORDS(DMA_WORDS),
    .AW(DMA_AW)
  ) u_dma_ram (
    .clock(clock),
    .reset(reset),
    .cpu_lanes(dma_cpu_lanes),
    .cpu_idx(dma_cpu_idx),
    .cpu_wdata(wr_data),
    .cpu_rdata(dma_cpu_rd),
    .dma_req(dma_req),
    .dma_we(dma_we),
    .dma_be(dma_be),
    .dma_idx(dma_word_addr),
    .dma_wdata(dma_wdata),
    .dma_rdata(dma_rdata),
    .dma_rvalid(dma_rvalid),
    .dma_collision(dma_collision)
  );

  // ==========================================
  // read path
  // sfr holes and unmapped space both fall to zero
  wire [15:0] word_rd = (region == dsau_pkg::REG_WREG) ? regs[ea[4:1]] :
                        (region == dsau_pkg::REG_RAM) ? ram[ram_idx] :
                        (region == dsau_pkg::REG_DMA) ? dma_cpu_rd : 16'h0000;
  wire [15:0] next_cpu_rdata = cpu_byte ? {8'h00, pick_byte(word_rd, ea[0])} : word_rd;
  wire rd_take = cpu_req && !cpu_we;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cpu_rdata <= 16'h0000;
      cpu_rvalid <= 1'b0;
      cpu_ea <= 16'h0000;
    end else begin
      cpu_rvalid <= rd_take;
      if (rd_take) begin
        cpu_rdata <= next_cpu_rdata;
      end
      if (cpu_req) begin
        cpu_ea <= ea;
      end
    end
  end

  // ==========================================
  // address error trap
  // misaligned read data is still returned so the instruction can finish
  dsau_pkg::dsau_trap_state_t trap_state;
  dsau_pkg::dsau_trap_state_t next_trap_state;
  wire err_seen = trap_state == dsau_pkg::TRAP_PENDING || misaligned;
  wire next_trap = err_seen && cpu_insn_done;

  always_comb begin
    next_trap_state = trap_state;
    case (trap_state)
      dsau_pkg::TRAP_IDLE: begin
        if (misaligned && !cpu_insn_done) begin
          next_trap_state = dsau_pkg::TRAP_PENDING;
        end
      end
      dsau_pkg::TRAP_PENDING: begin
        if (cpu_insn_done) begin
          next_trap_state = dsau_pkg::TRAP_IDLE;
        end
      end
      default: begin
        next_trap_state = dsau_pkg::TRAP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      trap_state <= dsau_pkg::TRAP_IDLE;
      addr_error_trap <= 1'b0;
    end else begin
      trap_state <= next_trap_state;
      addr_error_trap <= next_trap;
    end
  end

  // ==========================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  property p_post_inc;
    (inc_en && !(a_lanes != 2'b00 && a_idx == cpu_ptr_sel)) |=>
      regs[$past(cpu_ptr_sel)] == $past(ptr_value) + (($past(cpu_byte)) ? 16'h0001 : 16'h0002);
  endproperty
  a_post_inc: assert property (p_post_inc) else $error("pointer step wrong");

  property p_byte_read;
    (rd_take && cpu_byte) |=> cpu_rdata[15:8] == 8'h00 && cpu_rvalid;
  endproperty
  a_byte_read: assert property (p_byte_read) else $error("byte read high lane not zero");

  property p_lane_only;
    (!reg_op_valid && !inc_en && do_write && cpu_byte && wreg_hit && !ea[0]) |=>
      regs[$past(ea[4:1])][15:8] == $past(regs[ea[4:1]][15:8]);
  endproperty
  a_lane_only: assert property (p_lane_only) else $error("byte write hit other lane");

  property p_mis_pending;
    (misaligned && !cpu_insn_done) |=> trap_state == dsau_pkg::TRAP_PENDING;
  endproperty
  a_mis_pending: assert property (p_mis_pending) else $error("misaligned access not latched");

  property p_mis_no_write;
    (misaligned && cpu_we) |-> ram_lanes == 2'b00 && dma_cpu_lanes == 2'b00;
  endproperty
  a_mis_no_write: assert property (p_mis_no_write) else $error("misaligned write not suppressed");

  property p_trap_pulse;
    (trap_state == dsau_pkg::TRAP_PENDING && cpu_insn_done) |=> addr_error_trap ##1 !addr_error_trap;
  endproperty
  a_trap_pulse: assert property (p_trap_pulse) else $error("trap pulse wrong");

  property p_no_early_trap;
    (trap_state == dsau_pkg::TRAP_PENDING && !cpu_insn_done) |=> !addr_error_trap;
  endproperty
  a_no_early_trap: assert property (p_no_early_trap) else $error("trap before completion");

  property p_byte_load;
    (reg_op_valid && reg_op == dsau_pkg::OP_LOAD_BYTE && !inc_en) |=>
      regs[$past(reg_op_dst)] == {$past(op_src[15:8]), $past(reg_op_data[7:0])};
  endproperty
  a_byte_load: assert property (p_byte_load) else $error("byte load changed high byte");

  property p_sign_ext;
    (reg_op_valid && reg_op == dsau_pkg::OP_SIGN_EXT && !inc_en) |=>
      regs[$past(reg_op_dst)] == {{8{$past(op_src[7])}}, $past(op_src[7:0])};
  endproperty
  a_sign_ext: assert property (p_sign_ext) else $error("sign extend wrong");

  property p_zero_read;
    (rd_take && (region == dsau_pkg::REG_SFR || region == dsau_pkg::REG_NONE)) |=> cpu_rdata == 16'h0000;
  endproperty
  a_zero_read: assert property (p_zero_read) else $error("unmapped read not zero");

  c_misaligned_write: cover property (misaligned && cpu_we ##[1:8] addr_error_trap);
  c_dma_clash: cover property (dma_collision);
  c_post_inc_byte: cover property (inc_en && cpu_byte);
  c_dma_cpu_read: cover property (rd_take && region == dsau_pkg::REG_DMA);
endmodule : dsau_top
`default_nettype wire

//--- rtl/dsau_wreg_file.sv
// data space access unit: working register file
// assumes the caller resolves lane enables; port a beats the increment port
`timescale 1ns/1ps
`default_nettype none
`include "dsau_params.svh"

module dsau_wreg_file #(
  parameter int NUM_WREG = 16
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic [1:0] a_lanes,
  input wire logic [3:0] a_idx,
  input wire logic [15:0] a_data,
  input wire logic inc_en,
  input wire logic [3:0] inc_idx,
  input wire logic [15:0] inc_step,
  output logic [NUM_WREG-1:0][15:0] regs
);
  // ==========================================
  // write ports
  wire inc_hit = inc_en && !(a_lanes != 2'b00 && a_idx == inc_idx);

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < NUM_WREG; i++) begin
        regs[i] <= `DSAU_WREG_RESET;
      end
    end else begin
      if (inc_hit) begin
        regs[inc_idx] <= regs[inc_idx] + inc_step;
      end
      // untouched lane keeps its byte
      if (a_lanes[0]) begin
        regs[a_idx][7:0] <= a_data[7:0];
      end
      if (a_lanes[1]) begin
        regs[a_idx][15:8] <= a_data[15:8];
      end
    end
  end
endmodule : dsau_wreg_file
`default_nettype wire

//--- verification/data_space_access_unit_tb_top.sv
// self-checking bench for the data space access unit
// assumes dsau_top defaults and the dma stand-in model
`timescale 1ns/1ps
`default_nettype none

`define DSAU_CHECK(got, exp, msg) begin total_checks++; if ((got) !== (exp)) begin failures++; \
  $display("ERROR %0t %s got %h exp %h", $time, msg, got, exp); end end

module data_space_access_unit_tb_top;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic cpu_req = 1'b0, cpu_we = 1'b0, cpu_byte = 1'b0, cpu_post_inc = 1'b0, cpu_insn_done = 1'b0;
  dsau_pkg::dsau_mode_t cpu_mode = dsau_pkg::MODE_DIRECT16;
  logic [15:0] cpu_direct_addr = 16'h0000, cpu_wdata = 16'h0000, reg_op_data = 16'h0000;
  logic [3:0] cpu_ptr_sel = 4'h0, reg_op_dst = 4'h0;
  logic reg_op_valid = 1'b0;
  dsau_pkg::dsau_reg_op_t reg_op = dsau_pkg::OP_LOAD_WORD;
  logic dma_req, dma_we;
  logic [1:0] dma_be;
  logic [9:0] dma_word_addr;
  logic [15:0] dma_wdata, cpu_rdata, cpu_ea, dma_rdata;
  logic cpu_rvalid, addr_error_trap, dma_rvalid, dma_collision;
  int failures = 0;
  int total_checks = 0;
  logic [31:0] cq[$];
  logic [15:0] dq[$];
  logic [31:0] e;
  logic [15:0] seed = 16'h0042;
  logic [15:0] d0, d1, b, cv, dx;

  always #20 clock = ~clock;

  dsau_top uut (.clock(clock), .reset(reset), .cpu_req(cpu_req), .cpu_we(cpu_we), .cpu_byte(cpu_byte),
    .cpu_mode(cpu_mode), .cpu_direct_addr(cpu_direct_addr), .cpu_ptr_sel(cpu_ptr_sel),
    .cpu_post_inc(cpu_post_inc), .cpu_wdata(cpu_wdata), .cpu_insn_done(cpu_insn_done),
    .reg_op_valid(reg_op_valid), .reg_op(reg_op), .reg_op_dst(reg_op_dst), .reg_op_data(reg_op_data),
    .dma_req(dma_req), .dma_we(dma_we), .dma_be(dma_be), .dma_word_addr(dma_word_addr),
    .dma_wdata(dma_wdata), .cpu_rdata(cpu_rdata), .cpu_rvalid(cpu_rvalid), .cpu_ea(cpu_ea),
    .addr_error_trap(addr_error_trap), .dma_rdata(dma_rdata), .dma_rvalid(dma_rvalid),
    .dma_collision(dma_collision));

  dsau_dma_model dma (.clock(clock), .dma_req(dma_req), .dma_we(dma_we), .dma_be(dma_be),
    .dma_word_addr(dma_word_addr), .dma_wdata(dma_wdata));

  // ==========================================
  // stimulus helpers
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  task automatic cpu_go(input logic we, input logic byt, input dsau_pkg::dsau_mode_t m, input logic [15:0] a,
                        input logic [3:0] p, input logic pi, input logic [15:0] wd, input logic done);
    @(negedge clock);
    reg_op_valid = 1'b0;
    cpu_req = 1'b1;
    cpu_we = we;
    cpu_byte = byt;
    cpu_mode = m;
    cpu_direct_addr = a;
    cpu_ptr_sel = p;
    cpu_post_inc = pi;
    cpu_wdata = wd;
    cpu_insn_done = done;
  endtask : cpu_go

  task automatic rd(input dsau_pkg::dsau_mode_t m, input logic [15:0] a, input logic byt, input logic [3:0] p,
                    input logic pi, input logic [15:0] ea, input logic [15:0] x, input logic done);
    cq.push_back({ea, x});
    cpu_go(1'b0, byt, m, a, p, pi, 16'h0000, done);
  endtask : rd

  task automatic rop(input dsau_pkg::dsau_reg_op_t op, input logic [3:0] dst, input logic [15:0] d);
    @(negedge clock);
    cpu_req = 1'b0;
    reg_op_valid = 1'b1;
    reg_op = op;
    reg_op_dst = dst;
    reg_op_data = d;
  endtask : rop

  task automatic idle();
    @(negedge clock);
    cpu_req = 1'b0;
    reg_op_valid = 1'b0;
    cpu_insn_done = 1'b0;
    cpu_wdata = ~cpu_wdata;
    dma.quiet();
  endtask : idle

  task automatic summarize();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : summarize

  // ==========================================
  // result monitor, oldest note first
  always @(negedge clock) begin
    if (cpu_rvalid === 1'b1) begin
      e = cq.pop_front();
      `DSAU_CHECK(cpu_ea, e[31:16], "cpu ea")
      `DSAU_CHECK(cpu_rdata, e[15:0], "cpu read data")
    end
    // pop once, the macro evaluates its arguments twice
    if (dma_rvalid === 1'b1) begin
      dx = dq.pop_front();
      `DSAU_CHECK(dma_rdata, dx, "dma read data")
    end
  end

  initial begin
    repeat (2000) @(posedge clock);
    failures++;
    $display("ERROR %0t watchdog expired", $time);
    summarize();
  end

  // ==========================================
  // main sequence
  initial begin
    repeat (2) @(negedge clock);
    reset = 1'b0;
    for (int n = 0; n < 16; n++) begin
      rd(dsau_pkg::MODE_DIRECT16, 16'(2 * n), 1'b0, 4'h0, 1'b0, 16'(2 * n), 16'h0000, 1'b0);
    end
    seed = lfsr_next(seed);
    d0 = seed;
    seed = lfsr_next(seed);
    d1 = seed;
    seed = lfsr_next(seed);
    b = seed;
    // lanes and byte placement
    cpu_go(1'b1, 1'b0, dsau_pkg::MODE_DIRECT16, 16'h0800, 4'h0, 1'b0, d0, 1'b0);
    cpu_go(1'b1, 1'b0, dsau_pkg::MODE_DIRECT16, 16'h0802, 4'h0, 1'b0, d1, 1'b0);
    cpu_go(1'b1, 1'b1, dsau_pkg::MODE_DIRECT16, 16'h0801, 4'h0, 1'b0, b, 1'b0);
    rd(dsau_pkg::MODE_DIRECT16, 16'h0800, 1'b0, 4'h0, 1'b0, 16'h0800, {b[7:0], d0[7:0]}, 1'b0);
    rd(dsau_pkg::MODE_DIRECT16, 16'h0801, 1'b1, 4'h0, 1'b0, 16'h0801, {8'h00, b[7:0]}, 1'b0);
    cpu_go(1'b1, 1'b0, dsau_pkg::MODE_DIRECT16, 16'h0100, 4'h0, 1'b0, d1, 1'b0);
    rd(dsau_pkg::MODE_DIRECT16, 16'h0100, 1'b0, 4'h0, 1'b0, 16'h0100, 16'h0000, 1'b0);
    rd(dsau_pkg::MODE_DIRECT16, 16'h2800, 1'b0, 4'h0, 1'b0, 16'h2800, 16'h0000, 1'b0);
    rd(dsau_pkg::MODE_DIRECT13, 16'he802, 1'b0, 4'h0, 1'b0, 16'h0802, d1, 1'b0);
    // pointer steps, back to back
    rop(dsau_pkg::OP_LOAD_WORD, 4'h4, 16'h0800);
    rd(dsau_pkg::MODE_INDIRECT, 16'h0000, 1'b1, 4'h4, 1'b1, 16'h0800, {8'h00, d0[7:0]}, 1'b0);
    rd(dsau_pkg::MODE_INDIRECT, 16'h0000, 1'b1, 4'h4, 1'b1, 16'h0801, {8'h00, b[7:0]}, 1'b0);
    rd(dsau_pkg::MODE_INDIRECT, 16'h0000, 1'b0, 4'h4, 1'b1, 16'h0802, d1, 1'b0);
    rd(dsau_pkg::MODE_DIRECT16, 16'h0008, 1'b0, 4'h0, 1'b0, 16'h0008, 16'h0804, 1'b0);
    // register ops
    rop(dsau_pkg::OP_LOAD_WORD, 4'h6, 16'h1234);
    rop(dsau_pkg::OP_LOAD_BYTE, 4'h6, {d0[15:8], 8'h80});
    rd(dsau_pkg::MODE_DIRECT16, 16'h000c, 1'b0, 4'h0, 1'b0, 16'h000c, 16'h1280, 1'b0);
    rop(dsau_pkg::OP_SIGN_EXT, 4'h6, d1);
    rd(dsau_pkg::MODE_DIRECT16, 16'h000c, 1'b0, 4'h0, 1'b0, 16'h000c, 16'hff80, 1'b0);
    rop(dsau_pkg::OP_ZERO_EXT, 4'h6, d1);
    rd(dsau_pkg::MODE_DIRECT16, 16'h000c, 1'b0, 4'h0, 1'b0, 16'h000c, 16'h0080, 1'b0);
    // mapped byte writes into a working register, one lane each
    cpu_go(1'b1, 1'b1, dsau_pkg::MODE_DIRECT16, 16'h000c, 4'h0, 1'b0, d0, 1'b0);
    cpu_go(1'b1, 1'b1, dsau_pkg::MODE_DIRECT16, 16'h000d, 4'h0, 1'b0, d1, 1'b0);
    rd(dsau_pkg::MODE_DIRECT16, 16'h000c, 1'b0, 4'h0, 1'b0, 16'h000c, {d1[7:0], d0[7:0]}, 1'b0);
    idle();
    // misaligned write: dropped, trap waits a full cycle for completion
    cpu_go(1'b1, 1'b0, dsau_pkg::MODE_DIRECT16, 16'h0803, 4'h0, 1'b0, ~d1, 1'b0);
    idle();
    @(negedge clock);
    `DSAU_CHECK(addr_error_trap, 1'b0, "early trap")
    cpu_insn_done = 1'b1;
    @(negedge clock);
    cpu_insn_done = 1'b0;
    `DSAU_CHECK(addr_error_trap, 1'b1, "write trap")
    @(negedge clock);
    `DSAU_CHECK(addr_error_trap, 1'b0, "trap width")
    rd(dsau_pkg::MODE_DIRECT16, 16'h0802, 1'b0, 4'h0, 1'b0, 16'h0802, d1, 1'b0);
    // misaligned read still answers, trap with completion
    rd(dsau_pkg::MODE_DIRECT16, 16'h0801, 1'b0, 4'h0, 1'b0, 16'h0801, {b[7:0], d0[7:0]}, 1'b1);
    idle();
    `DSAU_CHECK(addr_error_trap, 1'b1, "read trap")
    // buffer ram shared with dma
    seed = lfsr_next(seed);
    cv = seed;
    dma.xfer(1'b1, 2'h3, 10'h005, d0);
    dq.push_back(d0);
    dma.xfer(1'b0, 2'h3, 10'h005, 16'h0000);
    rd(dsau_pkg::MODE_DIRECT16, 16'h200a, 1'b0, 4'h0, 1'b0, 16'h200a, d0, 1'b0);
    // one dma read only, a held request would answer again
    dma.quiet();
    fork
      cpu_go(1'b1, 1'b0, dsau_pkg::MODE_DIRECT16, 16'h200e, 4'h0, 1'b0, cv, 1'b0);
      dma.xfer(1'b1, 2'h3, 10'h007, ~cv);
    join
    idle();
    `DSAU_CHECK(dma_collision, 1'b1, "collision flag")
    dq.push_back(cv);
    fork
      rd(dsau_pkg::MODE_DIRECT16, 16'h200e, 1'b0, 4'h0, 1'b0, 16'h200e, cv, 1'b0);
      dma.xfer(1'b0, 2'h3, 10'h007, 16'h0000);
    join
    idle();
    repeat (3) @(negedge clock);
    `DSAU_CHECK(cq.size() + dq.size(), 0, "missing answers")
    summarize();
  end
endmodule : data_space_access_unit_tb_top
`default_nettype wire

//--- verification/dsau_dma_model.sv
// dma controller stand-in for the buffer ram port
// assumes the bench calls xfer and quiet at falling edges
`timescale 1ns/1ps
`default_nettype none

module dsau_dma_model (
  input wire logic clock,
  output logic dma_req,
  output logic dma_we,
  output logic [1:0] dma_be,
  output logic [9:0] dma_word_addr,
  output logic [15:0] dma_wdata
);
  // ==========================================
  // request driving
  initial begin
    dma_req = 1'b0;
    dma_we = 1'b0;
    dma_be = 2'h0;
    dma_word_addr = 10'h000;
    dma_wdata = 16'h0000;
  end

  // one request per cycle, held until quiet or the next xfer call
  task automatic xfer(input logic we, input logic [1:0] be, input logic [9:0] wa, input logic [15:0] wd);
    @(negedge clock);
    dma_req = 1'b1;
    dma_we = we;
    dma_be = be;
    dma_word_addr = wa;
    dma_wdata = wd;
  endtask : xfer

  // released bus shows no stale data
  task automatic quiet();
    dma_req = 1'b0;
    dma_wdata = ~dma_wdata;
    dma_word_addr = ~dma_word_addr;
  endtask : quiet
endmodule : dsau_dma_model
`default_nettype wire
